//--- logic/itfm_mapper.sv
// input terminal function mapper: top level
// assumes seven pins from switches or transistor outputs, settings over
// wishbone from the serial link controller, one clock, sync reset
// How it works
// - each of seven terminals binds one function
// - code zero drives nothing, level ignored
// - code one forward, code two backward
// - code nineteen picks instant or decelerating stop
// - code twenty releases brake while active
// - code twenty-two stops motor when inactive
// - code twenty-four clears present alarm
// - code twenty-seven tool unlock, normally closed
// - codes 32 to 47 give sixteen flags
// - codes 48 to 51 form operation index
// - code fifty-four inactive disables torque limiting
// - selects reset to the listed default codes
// - duplicated function other than a permissive acts when any terminal active, except overheat, which stops only when all are inactive
// - alarm clear fires on active-to-inactive edge
// - unassigned permissives read as always active
// - multiply assigned permissives need all sources active
// - contact bit one inverts terminal, default zero
// - network sources come from serial link writes
`timescale 1ns/1ps
`include "itfm_regs.svh"
module itfm_mapper (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           terminal_a,
  input  wire logic           terminal_b,
  input  wire logic           terminal_c,
  input  wire logic           terminal_d,
  input  wire logic           terminal_e,
  input  wire logic           terminal_f,
  input  wire logic           terminal_g,
  input  wire itfm_pkg::itfm_wb_req_t wb_req,
  output itfm_pkg::itfm_wb_rsp_t      wb_rsp,
  output itfm_pkg::itfm_fn_t          fn_out
);
  import itfm_pkg::*;

  // ----------------------------------------------------------------
  // pins and configuration
  // ----------------------------------------------------------------
  logic [6:0] term_pin;
  logic [6:0] term_sync;
  logic [6:0] eff;
  itfm_cfg_t  cfg;

  assign term_pin = {terminal_g, terminal_f, terminal_e, terminal_d,
                     terminal_c, terminal_b, terminal_a};

  // metastability settles before any decode sees a level
  itfm_sync #(
    .WIDTH    (7)
  ) u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .async_in (term_pin),
    .sync_out (term_sync)
  );

  itfm_regfile u_regs (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .wb_req     (wb_req),
    .wb_rsp     (wb_rsp),
    .cfg        (cfg),
    .fn_state   (fn_out),
    .term_level (eff)
  );

  // ----------------------------------------------------------------
  // per-terminal decode
  // ----------------------------------------------------------------
  logic [6:0]  hit_fwd;
  logic [6:0]  hit_bwd;
  logic [6:0]  hit_stop;
  logic [6:0]  hit_brake;
  logic [6:0]  hit_fault;
  logic [6:0]  hit_heat;
  logic [6:0]  hit_alm;
  logic [6:0]  hit_tool;
  logic [6:0]  hit_torq;
  logic [6:0]  hit_gp;
  logic [6:0]  hit_op;
  logic [15:0] gp_vec [7];
  logic [3:0]  op_vec [7];

  for (genvar i = 0; i < 7; i++) begin : g_term
    wire [7:0] code    = cfg.fsel[i];
    wire [7:0] gp_off  = code - `ITFM_FN_GP_FIRST;
    wire [7:0] op_off  = code - `ITFM_FN_OPSEL_A;
    assign eff[i]       = term_sync[i] ^ cfg.contact[i];
    // code zero and unlisted codes match no compare below
    assign hit_fwd[i]   = code == `ITFM_FN_FWD;
    assign hit_bwd[i]   = code == `ITFM_FN_BWD;
    assign hit_stop[i]  = code == `ITFM_FN_STOPMODE;
    assign hit_brake[i] = code == `ITFM_FN_BRAKE;
    assign hit_fault[i] = code == `ITFM_FN_EXTFAULT;
    assign hit_heat[i]  = code == `ITFM_FN_OVERHEAT;
    assign hit_alm[i]   = code == `ITFM_FN_ALMCLR;
    assign hit_tool[i]  = code == `ITFM_FN_TOOL;
    assign hit_torq[i]  = code == `ITFM_FN_TORQUE;
    assign hit_gp[i]    = (code >= `ITFM_FN_GP_FIRST) &&
                          (code <= `ITFM_FN_GP_LAST);
    assign hit_op[i]    = (code >= `ITFM_FN_OPSEL_A) &&
                          (code <= `ITFM_FN_OPSEL_D);
    assign gp_vec[i]    = hit_gp[i] && eff[i] ?
                          16'h0001 << gp_off[3:0] : 16'h0000;
    assign op_vec[i]    = hit_op[i] && eff[i] ?
                          4'h1 << op_off[1:0] : 4'h0;
  end

  // ----------------------------------------------------------------
  // combining across terminals
  // ----------------------------------------------------------------
  logic [15:0] gp_any;
  logic [3:0]  op_any;

  always_comb begin
    gp_any = 16'h0000;
    op_any = 4'h0;
    for (int i = 0; i < 7; i++) begin
      gp_any = gp_any | gp_vec[i];
      op_any = op_any | op_vec[i];
    end
  end

  // duplicates or together; unbound functions fall to zero
  wire fwd_any   = |(hit_fwd & eff);
  wire bwd_any   = |(hit_bwd & eff);
  wire stop_any  = |(hit_stop & eff);
  wire brake_any = |(hit_brake & eff);
  wire fault_any = |(hit_fault & eff);
  wire heat_ok   = |(hit_heat & eff);
  wire heat_req  = |hit_heat & ~heat_ok;
  wire alarm_now = |(hit_alm & eff);

  // permissives and over every source, so none bound means on
  wire tool_net_en  = cfg.net[`ITFM_NET_TOOL_EN];
  wire tool_net_ok  = ~tool_net_en | cfg.net[`ITFM_NET_TOOL_LVL];
  wire torq_net_en  = cfg.net[`ITFM_NET_TORQ_EN];
  wire torq_net_ok  = ~torq_net_en | cfg.net[`ITFM_NET_TORQ_LVL];
  wire tool_dir_ok  = &(eff | ~hit_tool);
  wire torq_dir_ok  = &(eff | ~hit_torq);
  wire tool_all     = tool_dir_ok & tool_net_ok;
  wire torq_all     = torq_dir_ok & torq_net_ok;
  wire tool_bound   = |hit_tool | tool_net_en;
  wire torq_bound   = |hit_torq | torq_net_en;

  // ----------------------------------------------------------------
  // alarm clear edge
  // ----------------------------------------------------------------
  logic alarm_prev;
  // a rising edge never clears, so a held button cannot re-arm
  wire  next_alarm_clear = alarm_prev & ~alarm_now;

  always_ff @(posedge clk) begin
    if (sys_rst) alarm_prev <= 1'b0;
    else         alarm_prev <= alarm_now;
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  itfm_fn_t next_fn;

  always_comb begin
    next_fn                        = '0;
    next_fn.forward_run            = fwd_any;
    next_fn.backward_run           = bwd_any;
    next_fn.decel_stop_sel         = stop_any;
    next_fn.brake_release          = brake_any;
    next_fn.external_fault         = fault_any;
    next_fn.motor_stop_req         = heat_req;
    next_fn.alarm_clear            = next_alarm_clear;
    next_fn.tool_unlock_permissive = tool_all;
    next_fn.torque_cap_permissive  = torq_all;
    next_fn.op_select              = op_any;
    next_fn.gp_flags               = gp_any;
  end

  // permissives start on: nothing is bound until selects load
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fn_out                        <= '0;
      fn_out.tool_unlock_permissive <= 1'b1;
      fn_out.torque_cap_permissive  <= 1'b1;
    end else begin
      fn_out <= next_fn;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_FWD_FROM_A: assert property (
    cfg.fsel[0] == `ITFM_FN_FWD && !cfg.contact[0] && term_sync[0]
    |=> fn_out.forward_run)
    else $error("forward not driven by its terminal");

  AST_BWD_ONLY_BOUND: assert property (
    hit_bwd == 7'h00 |=> !fn_out.backward_run)
    else $error("backward active with no terminal bound");

  AST_STOP_INVERTED: assert property (
    cfg.fsel[2] == `ITFM_FN_STOPMODE && cfg.contact[2] && !term_sync[2]
    |=> fn_out.decel_stop_sel)
    else $error("inverted contact not applied");

  AST_BRAKE_UNBOUND: assert property (
    hit_brake == 7'h00 |=> !fn_out.brake_release)
    else $error("brake released while unbound");

  AST_HEAT_STOP: assert property (
    hit_heat != 7'h00 && (hit_heat & eff) == 7'h00
    |=> fn_out.motor_stop_req)
    else $error("open overheat contact did not stop motor");

  AST_ALARM_FALL: assert property (
    fn_out.alarm_clear |-> $past(alarm_now, 2) && !$past(alarm_now))
    else $error("alarm clear without falling edge");

  AST_ALARM_NO_RISE: assert property (
    $rose(alarm_now) |=> !fn_out.alarm_clear ##1 !fn_out.alarm_clear)
    else $error("alarm clear on rising edge");

  AST_TOOL_UNBOUND: assert property (
    !tool_bound |=> fn_out.tool_unlock_permissive)
    else $error("unbound tool permissive not on");

  AST_TORQ_ALL: assert property (
    torq_bound && ((hit_torq & ~eff) != 7'h00 || !torq_net_ok)
    |=> !fn_out.torque_cap_permissive)
    else $error("torque permissive on with a source off");

  AST_GP_FIRST: assert property (
    cfg.fsel[3] == `ITFM_FN_GP_FIRST && eff[3] |=> fn_out.gp_flags[0])
    else $error("first general flag not set");

  AST_ZERO_IGNORED: assert property (
    cfg.fsel == '0 |=> fn_out.gp_flags == 16'h0000 &&
      fn_out.op_select == 4'h0 && !fn_out.forward_run)
    else $error("unused terminal drove a function");

  COV_ALARM_CLEAR: cover property (fn_out.alarm_clear);
  COV_TOOL_OFF: cover property (tool_bound ##1
    !fn_out.tool_unlock_permissive);
  COV_DUP_FWD: cover property ($countones(hit_fwd) > 1 &&
    fn_out.forward_run);
  COV_OP_INDEX: cover property (fn_out.op_select == 4'hF);

endmodule : itfm_mapper

//--- logic/itfm_pkg.sv
// types shared by the input terminal function mapper
// assumes itfm_regs.svh for all numeric constants
package itfm_pkg;

  // ----------------------------------------------------------------
  // bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } itfm_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } itfm_wb_rsp_t;

  // ----------------------------------------------------------------
  // configuration and function outputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0][7:0] fsel;
    logic [6:0]      contact;
    logic [3:0]      net;
  } itfm_cfg_t;

  typedef struct packed {
    logic [15:0] gp_flags;
    logic [3:0]  op_select;
    logic        torque_cap_permissive;
    logic        tool_unlock_permissive;
    logic        alarm_clear;
    logic        motor_stop_req;
    logic        external_fault;
    logic        brake_release;
    logic        decel_stop_sel;
    logic        backward_run;
    logic        forward_run;
  } itfm_fn_t;

endpackage : itfm_pkg

//--- logic/itfm_regfile.sv
// wishbone classic slave holding selects, contact types and net bits
// assumes one master, 32-bit words, ack one cycle after the strobe
`timescale 1ns/1ps
`include "itfm_regs.svh"
module itfm_regfile (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire itfm_pkg::itfm_wb_req_t wb_req,
  output itfm_pkg::itfm_wb_rsp_t      wb_rsp,
  output itfm_pkg::itfm_cfg_t         cfg,
  input  wire itfm_pkg::itfm_fn_t     fn_state,
  input  wire logic [6:0]     term_level
);
  import itfm_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        req      = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
  wire        wr_lo    = req & wb_req.we & wb_req.sel[0];
  wire [2:0]  fsel_idx = wb_req.adr[4:2];
  wire        fsel_hit = (wb_req.adr[7:5] == 3'h0) &&
                         (wb_req.adr[1:0] == 2'h0) &&
                         (wb_req.adr < `ITFM_ADR_CONTACT);
  wire        con_hit  = wb_req.adr == `ITFM_ADR_CONTACT;
  wire        net_hit  = wb_req.adr == `ITFM_ADR_NET;
  wire        st_hit   = wb_req.adr == `ITFM_ADR_STATUS;
  wire        gp_hit   = wb_req.adr == `ITFM_ADR_GPFLAG;
  wire [15:0] fn_bits  = fn_state[15:0];
  wire [31:0] st_word  = {9'h000, term_level, fn_bits};
  // unmapped words still ack and read zero
  wire [31:0] rd_data  =
    fsel_hit ? {24'h000000, cfg.fsel[fsel_idx]} :
    con_hit  ? {25'h0000000, cfg.contact} :
    net_hit  ? {28'h0000000, cfg.net} :
    st_hit   ? st_word :
    gp_hit   ? {16'h0000, fn_state.gp_flags} : 32'h00000000;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg.fsel <= {`ITFM_FSEL6_RST, `ITFM_FSEL5_RST, `ITFM_FSEL4_RST,
                   `ITFM_FSEL3_RST, `ITFM_FSEL2_RST, `ITFM_FSEL1_RST,
                   `ITFM_FSEL0_RST};
      cfg.contact <= `ITFM_CONTACT_RST;
      cfg.net     <= `ITFM_NET_RST;
    end else if (wr_lo) begin
      if (fsel_hit) cfg.fsel[fsel_idx] <= wb_req.dat[7:0];
      if (con_hit) cfg.contact <= wb_req.dat[6:0];
      if (net_hit) cfg.net <= wb_req.dat[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_rsp <= '0;
    end else begin
      wb_rsp.ack <= req;
      wb_rsp.dat <= req ? rd_data : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RESET_DEFAULTS: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> cfg.fsel[0] == `ITFM_FSEL0_RST &&
      cfg.fsel[3] == `ITFM_FSEL3_RST && cfg.fsel[6] == `ITFM_FSEL6_RST &&
      cfg.contact == `ITFM_CONTACT_RST)
    else $error("select defaults wrong after reset");

  AST_ACK_SINGLE: assert property (@(posedge clk) disable iff (sys_rst)
    wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");

endmodule : itfm_regfile

//--- logic/itfm_regs.svh
// register offsets, field positions, reset values and function codes
// assumes a 32-bit wishbone word per register, byte addresses
`ifndef ITFM_REGS_SVH
`define ITFM_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ITFM_ADR_FSEL_BASE 8'h00
`define ITFM_ADR_CONTACT   8'h1C
`define ITFM_ADR_NET       8'h20
`define ITFM_ADR_STATUS    8'h24
`define ITFM_ADR_GPFLAG    8'h28

// ----------------------------------------------------------------
// network control field positions
// ----------------------------------------------------------------
`define ITFM_NET_TOOL_EN   0
`define ITFM_NET_TOOL_LVL  1
`define ITFM_NET_TORQ_EN   2
`define ITFM_NET_TORQ_LVL  3

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define ITFM_ST_FN_LSB      0
`define ITFM_ST_TERM_LSB   16

// ----------------------------------------------------------------
// function codes
// ----------------------------------------------------------------
`define ITFM_FN_NONE       8'h00
`define ITFM_FN_FWD        8'h01
`define ITFM_FN_BWD        8'h02
`define ITFM_FN_STOPMODE   8'h13
`define ITFM_FN_BRAKE      8'h14
`define ITFM_FN_EXTFAULT   8'h15
`define ITFM_FN_OVERHEAT   8'h16
`define ITFM_FN_ALMCLR     8'h18
`define ITFM_FN_TOOL       8'h1B
`define ITFM_FN_GP_FIRST   8'h20
`define ITFM_FN_GP_LAST    8'h2F
`define ITFM_FN_OPSEL_A    8'h30
`define ITFM_FN_OPSEL_D    8'h33
`define ITFM_FN_TORQUE     8'h36

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ITFM_FSEL0_RST     8'h01
`define ITFM_FSEL1_RST     8'h02
`define ITFM_FSEL2_RST     8'h13
`define ITFM_FSEL3_RST     8'h30
`define ITFM_FSEL4_RST     8'h18
`define ITFM_FSEL5_RST     8'h14
`define ITFM_FSEL6_RST     8'h16
`define ITFM_CONTACT_RST   7'h00
`define ITFM_NET_RST       4'h0

`endif

//--- logic/itfm_sync.sv
// two-stage synchroniser for the terminal pins
// assumes asynchronous pin levels and a single clock
`timescale 1ns/1ps
module itfm_sync #(
  parameter int WIDTH = 7
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        stage1[g]   <= 1'b0;
        sync_out[g] <= 1'b0;
      end else begin
        stage1[g]   <= async_in[g];
        sync_out[g] <= stage1[g];
      end
    end
  end

endmodule : itfm_sync

//--- tb/input_terminal_function_mapper_tb.sv
// self-checking bench for the input terminal function mapper
// assumes itfm_pkg, itfm_regs.svh and the switch model are compiled first
`timescale 1ns/1ps
`include "itfm_regs.svh"
module input_terminal_function_mapper_tb;
  import itfm_pkg::*;
  logic            clk;
  logic            sys_rst;
  logic            slow;
  logic [6:0]      want;
  logic [6:0]      pin;
  itfm_wb_req_t    wb_req;
  itfm_wb_rsp_t    wb_rsp;
  itfm_fn_t        fn_out;
  int              failures;
  int              checks;
  int              n;
  logic [6:0][7:0] fs;
  logic [6:0]      ct;
  logic [3:0]      net;
  logic [31:0]     rd;
  // last entry is an unlisted code
  logic [7:0]      codes [18] = '{8'h00, 8'h01, 8'h02, 8'h13, 8'h14, 8'h15,
    8'h16, 8'h18, 8'h1B, 8'h20, 8'h27, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33,
    8'h36, 8'h3F};

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  itfm_mapper i_itfm_mapper (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .terminal_a (pin[0]),
    .terminal_b (pin[1]),
    .terminal_c (pin[2]),
    .terminal_d (pin[3]),
    .terminal_e (pin[4]),
    .terminal_f (pin[5]),
    .terminal_g (pin[6]),
    .wb_req     (wb_req),
    .wb_rsp     (wb_rsp),
    .fn_out     (fn_out)
  );

  itfm_switch_model i_itfm_switch_model (
    .clk  (clk),
    .slow (slow),
    .want (want),
    .pin  (pin)
  );

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ----------------------------------------------------------------
  // expected function outputs
  // ----------------------------------------------------------------
  function automatic itfm_fn_t exp_fn(input logic [6:0][7:0] f,
    input logic [6:0] c, input logic [3:0] nt, input logic [6:0] p);
    itfm_fn_t r;
    logic     e;
    logic     tool;
    logic     torq;
    logic     stop_bound;
    logic     stop_any;
    r = '0;
    tool = 1'b1;
    torq = 1'b1;
    stop_bound = 1'b0;
    stop_any = 1'b0;
    for (int i = 0; i < 7; i++) begin
      e = p[i] ^ c[i];
      case (f[i])
        8'h01: r.forward_run |= e;
        8'h02: r.backward_run |= e;
        8'h13: r.decel_stop_sel |= e;
        8'h14: r.brake_release |= e;
        8'h15: r.external_fault |= e;
        8'h16: begin
          stop_bound = 1'b1;
          stop_any |= e;
        end
        8'h1B: tool &= e;
        8'h36: torq &= e;
        default: begin
          if (f[i] >= 8'h20 && f[i] <= 8'h2F)
            r.gp_flags[f[i] - 8'h20] |= e;
          else if (f[i] >= 8'h30 && f[i] <= 8'h33)
            r.op_select[f[i] - 8'h30] |= e;
        end
      endcase
    end
    r.motor_stop_req = stop_bound & ~stop_any;
    r.tool_unlock_permissive = tool & (nt[0] ? nt[1] : 1'b1);
    r.torque_cap_permissive = torq & (nt[2] ? nt[3] : 1'b1);
    return r;
  endfunction : exp_fn

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // classic single cycle; entered just after a rising edge
  task automatic wb(input logic wr, input logic [7:0] adr,
    input logic [31:0] dat);
    int t;
    t = 0;
    wb_req <= '{cyc:1'b1, stb:1'b1, we:wr, adr:adr, sel:4'hF, dat:dat};
    do begin
      @(posedge clk);
      t++;
    end while (wb_rsp.ack !== 1'b1 && t < 50);
    if (t >= 50) begin
      failures++;
      test_done;
    end
    rd = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk);
  endtask : wb

  task automatic cfg_all;
    for (int i = 0; i < 7; i++)
      wb(1'b1, `ITFM_ADR_FSEL_BASE + 8'(4 * i), {24'hFFFFFF, fs[i]});
    wb(1'b1, `ITFM_ADR_CONTACT, {25'h0, ct});
    wb(1'b1, `ITFM_ADR_NET, {28'h0, net});
  endtask : cfg_all

  // two sync stages plus output register, with slack for slow relays
  task automatic settle_check;
    repeat (8) @(posedge clk);
    chk("fn_out", 32'(fn_out), 32'(exp_fn(fs, ct, net, want)));
  endtask : settle_check

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    test_done;
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hED8CCC22));
    failures = 0;
    checks = 0;
    sys_rst = 1'b1;
    slow = 1'b0;
    want = '0;
    wb_req = '0;
    fs = {`ITFM_FSEL6_RST, `ITFM_FSEL5_RST, `ITFM_FSEL4_RST,
      `ITFM_FSEL3_RST, `ITFM_FSEL2_RST, `ITFM_FSEL1_RST, `ITFM_FSEL0_RST};
    ct = '0;
    net = '0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    settle_check;
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, `ITFM_ADR_FSEL_BASE + 8'(4 * i), 32'h0);
      chk("fsel reset", rd, {24'h0, fs[i]});
    end
    wb(1'b0, `ITFM_ADR_CONTACT, 32'h0);
    chk("contact reset", rd, 32'h0);
    wb(1'b1, 8'h30, 32'hFFFFFFFF);
    wb(1'b0, 8'h30, 32'h0);
    chk("unmapped read", rd, 32'h0);
    $display("test reset done");

    // default terminal e clears the alarm; only the release may fire
    want <= 7'h10;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += int'(fn_out.alarm_clear === 1'b1);
    end
    chk("clear on press", 32'(n), 32'h0);
    want <= 7'h00;
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += int'(fn_out.alarm_clear === 1'b1);
    end
    chk("clear on release", 32'(n), 32'h1);
    $display("test alarm edge done");

    for (int it = 0; it < 60; it++) begin
      for (int i = 0; i < 7; i++)
        fs[i] = codes[$urandom_range(17, 0)];
      fs[0] = codes[it % 18];
      // forced duplicate bindings on every fifth pass
      if (it % 5 == 0)
        fs[6] = fs[5];
      ct = 7'($urandom);
      net = 4'($urandom);
      cfg_all;
      wb(1'b0, `ITFM_ADR_FSEL_BASE + 8'h18, 32'h0);
      chk("fsel readback", rd, {24'h0, fs[6]});
      repeat (3) begin
        slow <= 1'($urandom);
        want <= 7'($urandom);
        settle_check;
      end
    end
    $display("test random mapping done");
    test_done;
  end
endmodule : input_terminal_function_mapper_tb

//--- tb/itfm_switch_model.sv
// external switch and transistor model driving the seven terminals
// assumes one bench clock; contacts change only when told to
`timescale 1ns/1ps
module itfm_switch_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic [6:0] want,
  output logic      [6:0] pin
);
  // ----------------------------------------------------------------
  // contact delay
  // ----------------------------------------------------------------
  logic [6:0] stage_a;
  logic [6:0] stage_b;

  // slow relays lag two cycles; the mapper must still settle on them
  always @(posedge clk) begin
    stage_a <= want;
    stage_b <= stage_a;
  end

  assign pin = slow ? stage_b : want;
endmodule : itfm_switch_model
